// File: verilog/acq_trigger_defines.vh
`ifndef ACQ_TRIGGER_DEFINES_VH
`define ACQ_TRIGGER_DEFINES_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_BUF_SIZE 8'h04
`define REG_PRE_COUNT 8'h08
`define REG_REF_CFG 8'h0c
`define REG_PAUSE_CFG 8'h10
`define REG_SYNC_TIME 8'h14
`define REG_STATUS 8'h18
`define REG_WR_PTR 8'h1c
`define REG_TIME_NOW 8'h20
`define REG_SAMPLE_DIV 8'h24

// ctrl bits (write one to act)
`define CTRL_SW_START 0
`define CTRL_START_TRIG_EN 1
`define CTRL_REF_EN 2
`define CTRL_ABORT 3
`define CTRL_SYNC_SW 4
`define CTRL_SYNC_TIME_EN 5
`define CTRL_MULTI_CHASSIS 6

// trigger config fields
`define CFG_SEL_LSB 0
`define CFG_SEL_MSB 4
`define CFG_POL 8
`define CFG_ANALOG 9

// source select codes above the terminals
`define SEL_TERM_COUNT 8
`define SEL_INT_BASE 8

// reset values
`define BUF_SIZE_RST 16'h0010
`define PRE_COUNT_RST 16'h0004
`define SAMPLE_DIV_RST 16'h0013

// buffer
`define BUF_DEPTH 16
`define BUF_AW 4

// acquisition states
`define ST_IDLE 3'h0
`define ST_PRE 3'h1
`define ST_ARMED 3'h2
`define ST_POST 3'h3
`define ST_DONE 3'h4

`endif

// File: verilog/acquisition_trigger_control.v
// How it works
// - posttrigger count is size minus pretrigger
// - every sample after start is stored
// - reference detection armed after pretrigger samples
// - earlier reference conditions are ignored
// - full buffer drops oldest sample
// - after trigger, store posttrigger samples then stop
// - digital reference on selectable edge
// - reference source: terminal or internal signal
// - analog reference stops on configured edge
// - reference output is active high
// - pause holds sample clock, release restarts
// - pause active level is configurable
// - pause source: terminal or internal signal
// - analog pause gates on configured level
// - pause responds to level only
// - sync pulse issued at programmed time
// - shared sync or software sync per task
// - multi-chassis sync and start follow shared link
// - start by trigger or software command
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acq_trigger_defines.vh"

module acquisition_trigger_control
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // trigger sources
  input wire [7:0] programmable_function_terminal,
  input wire [7:0] internal_signal,
  input wire analog_compare_event,
  input wire start_trigger_in,
  input wire [31:0] time_now,
  input wire shared_sync_in,
  input wire shared_start_in,
  // sample data
  input wire [15:0] sample_data,
  // outputs
  output reg sample_clock,
  output reg ref_trigger_out,
  output reg sync_pulse,
  output reg acq_done,
  output reg [15:0] buf_rd_data,
  output reg buf_wr_en,
  output reg [3:0] buf_wr_addr
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function pick_source;
    input [9:0] cfg;
    input [7:0] term;
    input [7:0] intl;
    input analog;
    reg [4:0] sel;
    begin
      sel = cfg[`CFG_SEL_MSB:`CFG_SEL_LSB];
      if (cfg[`CFG_ANALOG])
        pick_source = analog;
      else if (sel < `SEL_TERM_COUNT)
        pick_source = term[sel[2:0]];
      else
        pick_source = intl[sel[2:0]];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [6:0] ctrl;
  reg [15:0] buf_size;
  reg [15:0] pre_count;
  reg [9:0] ref_cfg;
  reg [9:0] pause_cfg;
  reg [31:0] sync_time;
  reg [15:0] sample_div;
  reg [2:0] state;
  reg [15:0] stored;
  reg [15:0] post_left;
  reg [3:0] wr_ptr;
  reg [15:0] mem [0:`BUF_DEPTH-1];
  reg [15:0] div_cnt;
  reg ref_prev;
  reg start_prev;
  reg sync_armed;
  reg [3:0] rd_idx;

  reg have_aw;
  reg have_w;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [15:0] post_count = buf_size - pre_count;
  // merged words are 32 bits; each register keeps only its own slice
  wire [31:0] buf_size_m = merge({16'h0, buf_size}, w_data, w_strb);
  wire [31:0] pre_count_m = merge({16'h0, pre_count}, w_data, w_strb);
  wire [31:0] ref_cfg_m = merge({22'h0, ref_cfg}, w_data, w_strb);
  wire [31:0] pause_cfg_m = merge({22'h0, pause_cfg}, w_data, w_strb);
  wire [31:0] sample_div_m = merge({16'h0, sample_div}, w_data, w_strb);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !have_aw && !s_axi_bvalid;
  assign s_axi_wready = !have_w && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_go = have_aw && have_w;
  wire ctrl_wr = wr_go && aw_addr == `REG_CTRL;
  wire [6:0] ctrl_pulse = ctrl_wr ? w_data[6:0] & {7{w_strb[0]}} : 7'h00;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= 7'h00;
      buf_size <= `BUF_SIZE_RST;
      pre_count <= `PRE_COUNT_RST;
      ref_cfg <= 10'h000;
      pause_cfg <= 10'h000;
      sync_time <= 32'h0;
      sample_div <= `SAMPLE_DIV_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          // level bits only; action bits are one-cycle pulses
          `REG_CTRL:
            if (w_strb[0])
              ctrl <= {w_data[6:5], 2'b00, w_data[2:1], 1'b0};
          `REG_BUF_SIZE:
            buf_size <= buf_size_m[15:0];
          `REG_PRE_COUNT:
            pre_count <= pre_count_m[15:0];
          `REG_REF_CFG:
            ref_cfg <= ref_cfg_m[9:0];
          `REG_PAUSE_CFG:
            pause_cfg <= pause_cfg_m[9:0];
          `REG_SYNC_TIME:
            sync_time <= merge(sync_time, w_data, w_strb);
          `REG_SAMPLE_DIV:
            sample_div <= sample_div_m[15:0];
          `REG_STATUS, `REG_WR_PTR, `REG_TIME_NOW:
            s_axi_bresp <= 2'h0;
          default:
            s_axi_bresp <= 2'h2;
        endcase
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= {25'h0, ctrl};
        `REG_BUF_SIZE: s_axi_rdata <= {16'h0, buf_size};
        `REG_PRE_COUNT: s_axi_rdata <= {16'h0, pre_count};
        `REG_REF_CFG: s_axi_rdata <= {22'h0, ref_cfg};
        `REG_PAUSE_CFG: s_axi_rdata <= {22'h0, pause_cfg};
        `REG_SYNC_TIME: s_axi_rdata <= sync_time;
        `REG_STATUS: s_axi_rdata <= {13'h0, state, stored};
        `REG_WR_PTR: s_axi_rdata <= {28'h0, wr_ptr};
        `REG_TIME_NOW: s_axi_rdata <= time_now;
        `REG_SAMPLE_DIV: s_axi_rdata <= {16'h0, sample_div};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // triggers and sample clock
  // ----------------------------------------------------------------
  wire ref_src = pick_source(ref_cfg, programmable_function_terminal,
    internal_signal, analog_compare_event);
  wire pause_src = pick_source(pause_cfg, programmable_function_terminal,
    internal_signal, analog_compare_event);
  // level compare only, no edge memory on this path
  wire paused = (pause_src == pause_cfg[`CFG_POL]);
  // pol 0 rising, pol 1 falling
  wire ref_edge = ref_cfg[`CFG_POL] ? (ref_prev && !ref_src)
    : (!ref_prev && ref_src);
  wire start_src = ctrl[`CTRL_MULTI_CHASSIS] ? shared_start_in
    : start_trigger_in;
  wire start_hit = ctrl[`CTRL_START_TRIG_EN] ? (start_src && !start_prev)
    : ctrl_pulse[`CTRL_SW_START];
  wire running = state == `ST_PRE || state == `ST_ARMED
    || state == `ST_POST;
  // a pause freezes the divider so the next sample is not shortened
  wire tick = running && !paused && div_cnt == 16'h0;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_prev <= 1'b0;
      start_prev <= 1'b0;
      div_cnt <= 16'h0;
      sample_clock <= 1'b0;
    end
    else
    begin
      ref_prev <= ref_src;
      start_prev <= start_src;
      sample_clock <= tick;
      if (!running)
        div_cnt <= sample_div;
      else if (!paused)
        div_cnt <= (div_cnt == 16'h0) ? sample_div : div_cnt - 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // acquisition sequence
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= `ST_IDLE;
      stored <= 16'h0;
      post_left <= 16'h0;
      wr_ptr <= 4'h0;
      buf_wr_en <= 1'b0;
      buf_wr_addr <= 4'h0;
      ref_trigger_out <= 1'b0;
      acq_done <= 1'b0;
    end
    else
    begin
      buf_wr_en <= 1'b0;
      ref_trigger_out <= 1'b0;
      if (ctrl_pulse[`CTRL_ABORT])
        state <= `ST_IDLE;
      else
        case (state)
          `ST_IDLE, `ST_DONE:
            if (start_hit)
            begin
              state <= `ST_PRE;
              stored <= 16'h0;
              wr_ptr <= 4'h0;
              acq_done <= 1'b0;
            end
          `ST_PRE:
            // reference edges here are dropped
            if (tick)
            begin
              if (!ctrl[`CTRL_REF_EN] && stored + 16'h1 >= buf_size)
              begin
                state <= `ST_DONE;
                acq_done <= 1'b1;
              end
              else if (ctrl[`CTRL_REF_EN] && stored + 16'h1 >= pre_count)
                state <= `ST_ARMED;
            end
          `ST_ARMED:
            if (ref_edge)
            begin
              ref_trigger_out <= 1'b1;
              post_left <= post_count;
              if (post_count == 16'h0)
              begin
                state <= `ST_DONE;
                acq_done <= 1'b1;
              end
              else
                state <= `ST_POST;
            end
          `ST_POST:
            if (tick && post_left == 16'h1)
            begin
              state <= `ST_DONE;
              acq_done <= 1'b1;
            end
          default:
            state <= `ST_IDLE;
        endcase
      if (tick)
      begin
        mem[wr_ptr] <= sample_data;
        buf_wr_en <= 1'b1;
        buf_wr_addr <= wr_ptr;
        // wrap overwrites the oldest slot
        wr_ptr <= wr_ptr + 4'h1;
        if (stored < buf_size)
          stored <= stored + 16'h1;
        if (state == `ST_POST)
          post_left <= post_left - 16'h1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_idx <= 4'h0;
      buf_rd_data <= 16'h0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_WR_PTR)
        rd_idx <= rd_idx + 4'h1;
      buf_rd_data <= mem[rd_idx];
    end
  end

  // ----------------------------------------------------------------
  // sync pulse
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_armed <= 1'b0;
      sync_pulse <= 1'b0;
    end
    else
    begin
      sync_pulse <= 1'b0;
      if (ctrl_pulse[`CTRL_SYNC_TIME_EN])
        sync_armed <= 1'b1;
      if (ctrl[`CTRL_MULTI_CHASSIS])
        sync_pulse <= shared_sync_in;
      else if (sync_armed && time_now >= sync_time)
      begin
        sync_pulse <= 1'b1;
        sync_armed <= 1'b0;
      end
      else if (ctrl_pulse[`CTRL_SYNC_SW])
        sync_pulse <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: sim/acq_trigger_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acq_trigger_sva
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // acquisition
  input wire logic ref_trigger_out,
  input wire logic sync_pulse,
  input wire logic acq_done,
  input wire logic buf_wr_en,
  input wire logic [3:0] buf_wr_addr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----
  // last write slot
  // ----
  // a new run may restart the slot, so history drops at done
  logic have_prev;
  logic [3:0] last_addr;
  always @(posedge aclk)
  begin
    if (!aresetn || acq_done)
      have_prev <= 1'b0;
    else if (buf_wr_en)
      have_prev <= 1'b1;
    if (buf_wr_en)
      last_addr <= buf_wr_addr;
  end
  // ----
  // properties
  // ----
  chk_bvalid_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid withdrawn");
  chk_rvalid_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid withdrawn");
  chk_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  chk_ref_pulse: assert property (
    ref_trigger_out |=> !ref_trigger_out)
    else $error("reference pulse too long");
  chk_ref_not_done: assert property (
    ref_trigger_out |-> !acq_done ##1 !acq_done)
    else $error("run ended without posttrigger samples");
  chk_sync_pulse: assert property (
    sync_pulse |=> !sync_pulse)
    else $error("sync pulse too long");
  chk_done_quiet: assert property (
    acq_done && $past(acq_done) |-> !buf_wr_en)
    else $error("sample stored after end");
  chk_slot_step: assert property (
    buf_wr_en && have_prev |-> buf_wr_addr == last_addr + 4'h1)
    else $error("write slot skipped");
  chk_reset_clear: assert property (
    $rose(aresetn) |-> !ref_trigger_out && !sync_pulse && !acq_done)
    else $error("outputs set after reset");
  cover property (ref_trigger_out);
  cover property (sync_pulse);
  cover property ($rose(acq_done));
endmodule
bind acquisition_trigger_control acq_trigger_sva u_sva (.aclk, .aresetn,
  .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .ref_trigger_out, .sync_pulse, .acq_done,
  .buf_wr_en, .buf_wr_addr);
`default_nettype wire

// File: sim/sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module sample_source
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // from the block and the bench
  input wire logic sample_clock,
  input wire logic ana_level,
  // to the block
  output logic [15:0] sample_data,
  output logic analog_compare_event
);
  // ----
  // converter front end
  // ----
  // fresh value per tick, so a stuck capture would show
  always @(posedge aclk)
  begin
    if (!aresetn)
      sample_data <= 16'h0000;
    else if (sample_clock)
      sample_data <= sample_data + 16'h0001;
  end
  // no filtering: the compare level reaches the block as commanded
  assign analog_compare_event = ana_level;
endmodule
`default_nettype wire

// File: sim/acquisition_trigger_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acq_trigger_defines.vh"
module acquisition_trigger_control_bench;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, ana_level;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_clock;
  logic ref_trigger_out, sync_pulse, acq_done, buf_wr_en;
  logic analog_compare_event;
  logic [7:0] s_axi_awaddr, s_axi_araddr, term, intl;
  logic [31:0] s_axi_wdata, s_axi_rdata, time_now;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] sample_data, buf_rd_data;
  logic [3:0] buf_wr_addr;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [1:0] last_bresp;
  acquisition_trigger_control dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .programmable_function_terminal(term), .internal_signal(intl),
    .analog_compare_event, .start_trigger_in(1'b0), .time_now,
    .shared_sync_in(1'b0), .shared_start_in(1'b0), .sample_data,
    .sample_clock, .ref_trigger_out, .sync_pulse, .acq_done, .buf_rd_data,
    .buf_wr_en, .buf_wr_addr);
  sample_source src (.aclk, .aresetn, .sample_clock, .ana_level,
    .sample_data, .analog_compare_event);
  // ----
  // clock, time base, timeout
  // ----
  always #25 aclk = ~aclk;
  always @(posedge aclk)
  begin
    time_now <= time_now + 32'h1;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test;
    end
  end
  // ----
  // helpers
  // ----
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // edge first so a release never meets a new request in one step
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task setsrc(input int s, input logic v);
    if (s == 2)
      ana_level <= v;
    else if (s == 1)
      intl <= {7'h00, v};
    else
      term <= {7'h00, v};
  endtask
  // stores counted only after a reference pulse unless all is set
  task watch(input int c, input logic all, output int rf, output int sm,
    output int sy);
    rf = 0;
    sm = 0;
    sy = 0;
    repeat (c)
    begin
      @(posedge aclk);
      if ((all || rf != 0) && buf_wr_en)
        sm++;
      if (ref_trigger_out)
        rf++;
      if (sync_pulse)
        sy++;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`REG_BUF_SIZE, d, r);
    chk("buf_size", {16'h0, `BUF_SIZE_RST}, d);
    rd(`REG_PRE_COUNT, d, r);
    chk("pre_count", {16'h0, `PRE_COUNT_RST}, d);
    rd(8'h40, d, r);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(8'h40, 32'h0);
    chk("unmapped write", 32'h2, {30'h0, last_bresp});
    wr(`REG_SAMPLE_DIV, 32'h1);
    chk("good write", 32'h0, {30'h0, last_bresp});
  endtask
  task t_ref(input logic [31:0] cfg, input int s, input logic lv);
    int rf, sm, sy, r2;
    logic [31:0] d;
    logic [1:0] r;
    wr(`REG_BUF_SIZE, 32'h8);
    wr(`REG_PRE_COUNT, 32'h3);
    wr(`REG_REF_CFG, cfg);
    setsrc(s, !lv);
    wr(`REG_CTRL, 32'h5);
    setsrc(s, lv);
    watch(40, 1'b1, rf, sm, sy);
    chk("stores while armed", 1, {31'h0, sm > 8});
    setsrc(s, !lv);
    watch(10, 1'b1, r2, sm, sy);
    chk("early or wrong edge", 0, rf + r2);
    chk("running", 0, {31'h0, acq_done});
    setsrc(s, lv);
    watch(60, 1'b0, rf, sm, sy);
    chk("ref pulses", 1, rf);
    chk("post samples", 5, sm);
    rd(`REG_STATUS, d, r);
    chk("state", {29'h0, `ST_DONE}, {29'h0, d[18:16]});
  endtask
  task t_pause(input logic [31:0] cfg, input int s, input logic lv);
    int rf, sm, sy;
    wr(`REG_BUF_SIZE, 32'h10);
    wr(`REG_PAUSE_CFG, cfg);
    setsrc(s, lv);
    wr(`REG_CTRL, 32'h1);
    watch(30, 1'b1, rf, sm, sy);
    chk("paused samples", 0, sm);
    setsrc(s, !lv);
    watch(80, 1'b1, rf, sm, sy);
    chk("resumed samples", 16, sm);
    chk("done", 1, {31'h0, acq_done});
  endtask
  task t_sync;
    int rf, sm, sy, k;
    logic [31:0] t;
    wr(`REG_CTRL, 32'h10);
    // the pulse stands in the cycle in which the response is seen
    chk("sw sync", 1, {31'h0, sync_pulse});
    watch(8, 1'b1, rf, sm, sy);
    chk("extra sw sync", 0, sy);
    t = time_now + 32'd40;
    wr(`REG_SYNC_TIME, t);
    wr(`REG_CTRL, 32'h20);
    watch(20, 1'b1, rf, sm, sy);
    chk("early sync", 0, sy);
    k = 0;
    while (!sync_pulse && k < 60)
    begin
      @(posedge aclk);
      k++;
    end
    chk("sync time", 1, {31'h0, time_now - t <= 32'd3});
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, ana_level} <= 3'h0;
    {s_axi_awaddr, s_axi_araddr, term, intl} <= 32'h0;
    {s_axi_wdata, time_now} <= 64'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_pause(32'h108, 1, 1'b1);
    t_ref(32'h0, 0, 1'b1);
    t_ref(32'h300, 2, 1'b0);
    t_pause(32'h200, 2, 1'b0);
    t_sync;
    finish_test;
  end
endmodule
`default_nettype wire
